// *** design/flags_if.sv ***
// Carrier between the command logic and the protection flag store
`timescale 1ns/1ps
interface flags_if;
  logic glob_set;
  logic glob_clr;
  sector_protection_lock_pkg::sector_t sector;
  logic flag;
  logic all_prot;
  logic any_prot;
  modport owner (output glob_set, output glob_clr, output sector,
    input flag, input all_prot, input any_prot);
  modport store (input glob_set, input glob_clr, input sector,
    output flag, output all_prot, output any_prot);
endinterface

// *** design/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_q <= 1'h0;
          sync_q <= 1'h0;
        end
        else
        begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule

// *** design/protect_flags.sv ***
// Sixteen sector protection flags with registered read and summary
`timescale 1ns/1ps
`include "sector_protection_lock_params.svh"
module protect_flags (
  input wire logic clk,
  input wire logic rst,
  flags_if.store fl
);
  logic [`SECTOR_COUNT-1:0] flags_q;
  logic [`SECTOR_COUNT-1:0] flags_d;
  logic flag_q;
  logic all_q;
  logic any_q;

  always_comb
  begin
    flags_d = flags_q;
    if (fl.glob_set)
      flags_d = '1;
    else if (fl.glob_clr)
      flags_d = '0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_q <= `FLAGS_RESET;
      flag_q <= 1'h1;
      all_q <= 1'h1;
      any_q <= 1'h1;
    end
    else
    begin
      flags_q <= flags_d;
      flag_q <= flags_q[fl.sector];
      all_q <= &flags_q;
      any_q <= |flags_q;
    end
  end

  assign fl.flag = flag_q;
  assign fl.all_prot = all_q;
  assign fl.any_prot = any_q;
endmodule

// *** design/sector_protection_lock.sv ***
// Status write decoding, lock bit and protection query over the serial pins
`timescale 1ns/1ps
`include "sector_protection_lock_params.svh"
module sector_protection_lock (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic protection_lock_bit,
  output logic [1:0] protection_summary_field
);
  // ========================================================================
  // Pin synchronisation
  logic [3:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;

  pin_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({cs_n, sck, si, wp_n}),
    .dout(pins_s)
  );
  assign cs_n_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  // ========================================================================
  // Flag store
  flags_if fl ();
  protect_flags u_flags (
    .clk(clk),
    .rst(rst),
    .fl(fl.store)
  );

  // ========================================================================
  // State
  sector_protection_lock_pkg::state_t state_q;
  sector_protection_lock_pkg::state_t state_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [2:0] ocnt_q;
  logic [2:0] ocnt_d;
  sector_protection_lock_pkg::byte_t shift_q;
  sector_protection_lock_pkg::byte_t shift_d;
  logic [1:0] abyte_q;
  logic [1:0] abyte_d;
  sector_protection_lock_pkg::sector_t sector_q;
  sector_protection_lock_pkg::sector_t sector_d;
  logic sck_prev_q;
  logic so_q;
  logic so_d;
  logic so_oe_q;
  logic so_oe_d;
  logic lock_q;
  logic lock_d;
  logic glob_set_q;
  logic glob_set_d;
  logic glob_clr_q;
  logic glob_clr_d;
  logic [1:0] summary_q;
  logic [1:0] summary_d;

  // Helpers shared by the logic and the checks
  logic rise;
  logic fall;
  logic byte_done;
  logic wsr_done;
  logic hw_locked;
  logic in_status;
  logic in_query;
  sector_protection_lock_pkg::byte_t byte_in;
  sector_protection_lock_pkg::byte_t status_now;

  // ========================================================================
  // Decoding
  function automatic logic [1:0] summary_code(input logic all_p, input logic any_p);
    if (all_p)
      summary_code = `SUMMARY_ALL;
    else if (any_p)
      summary_code = `SUMMARY_SOME;
    else
      summary_code = `SUMMARY_NONE;
  endfunction

  function automatic sector_protection_lock_pkg::byte_t status_byte(
    input logic lock, input logic pin_n, input logic all_p, input logic any_p);
    status_byte = 8'h00;
    status_byte[`LOCK_BIT] = lock;
    status_byte[`PIN_BIT] = pin_n;
    status_byte[`SUMMARY_HI:`SUMMARY_LO] = summary_code(all_p, any_p);
  endfunction

  assign rise = sck_s & ~sck_prev_q;
  assign fall = ~sck_s & sck_prev_q;
  assign byte_in = {shift_q[6:0], si_s};
  assign byte_done = ~cs_n_s & rise & (bit_q == `BIT_LAST);
  assign wsr_done = byte_done & (state_q == sector_protection_lock_pkg::WSR_DATA);
  assign in_status = (state_q == sector_protection_lock_pkg::STATUS_OUT);
  assign in_query = (state_q == sector_protection_lock_pkg::QUERY_OUT);
  assign hw_locked = lock_q & ~wp_n_s;
  // Bits 4..2 come from live state and bit 5 reads zero, never from written data
  assign status_now = status_byte(lock_q, wp_n_s, fl.all_prot, fl.any_prot);

  // ========================================================================
  // Command sequencing
  always_comb
  begin
    state_d = state_q;
    bit_d = bit_q;
    ocnt_d = ocnt_q;
    shift_d = shift_q;
    abyte_d = abyte_q;
    sector_d = sector_q;
    so_d = so_q;
    so_oe_d = so_oe_q;
    lock_d = lock_q;
    glob_set_d = 1'h0;
    glob_clr_d = 1'h0;
    summary_d = summary_code(fl.all_prot, fl.any_prot);
    if (cs_n_s)
    begin
      state_d = sector_protection_lock_pkg::OPCODE_IN;
      bit_d = 3'h0;
      ocnt_d = 3'h0;
      abyte_d = 2'h0;
      so_oe_d = 1'h0;
    end
    else
    begin
      if (rise)
      begin
        shift_d = byte_in;
        bit_d = bit_q + 3'h1;
      end
      if (byte_done)
      begin
        unique case (state_q)
          sector_protection_lock_pkg::OPCODE_IN:
          begin
            if (byte_in == `OP_WRITE_STATUS)
              state_d = sector_protection_lock_pkg::WSR_DATA;
            else if (byte_in == `OP_READ_STATUS)
              state_d = sector_protection_lock_pkg::STATUS_OUT;
            else if (byte_in == `OP_READ_PROTECT)
              state_d = sector_protection_lock_pkg::ADDR_IN;
            else
              state_d = sector_protection_lock_pkg::IGNORE;
          end
          sector_protection_lock_pkg::WSR_DATA:
          begin
            // Hard lock freezes both lock bit and flags
            if (!hw_locked)
            begin
              lock_d = byte_in[`LOCK_BIT];
              // Global action only when the lock was clear before this write
              if (!lock_q)
              begin
                // Mixed patterns fall through with no action
                if (byte_in[`GLOBAL_HI:`GLOBAL_LO] == `GLOBAL_NONE)
                  glob_clr_d = 1'h1;
                else if (byte_in[`GLOBAL_HI:`GLOBAL_LO] == `GLOBAL_ALL)
                  glob_set_d = 1'h1;
              end
            end
            state_d = sector_protection_lock_pkg::IGNORE;
          end
          sector_protection_lock_pkg::ADDR_IN:
          begin
            // First address byte holds bits 23..16
            if (abyte_q == `ADDR_BYTE_SECTOR)
              sector_d = byte_in[3:0];
            abyte_d = abyte_q + 2'h1;
            if (abyte_q == `ADDR_BYTE_LAST)
              state_d = sector_protection_lock_pkg::QUERY_OUT;
          end
          sector_protection_lock_pkg::STATUS_OUT,
          sector_protection_lock_pkg::QUERY_OUT,
          sector_protection_lock_pkg::IGNORE:
          begin
          end
        endcase
      end
      if (fall && (in_status || in_query))
      begin
        so_oe_d = 1'h1;
        ocnt_d = ocnt_q + 3'h1;
        if (in_status)
          so_d = status_now[3'h7 - ocnt_q];
        else
          so_d = fl.flag;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= sector_protection_lock_pkg::OPCODE_IN;
      bit_q <= 3'h0;
      ocnt_q <= 3'h0;
      shift_q <= 8'h00;
      abyte_q <= 2'h0;
      sector_q <= 4'h0;
      sck_prev_q <= 1'h0;
      so_q <= 1'h0;
      so_oe_q <= 1'h0;
      lock_q <= `LOCK_RESET;
      glob_set_q <= 1'h0;
      glob_clr_q <= 1'h0;
      summary_q <= `SUMMARY_ALL;
    end
    else
    begin
      state_q <= state_d;
      bit_q <= bit_d;
      ocnt_q <= ocnt_d;
      shift_q <= shift_d;
      abyte_q <= abyte_d;
      sector_q <= sector_d;
      sck_prev_q <= sck_s;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      lock_q <= lock_d;
      glob_set_q <= glob_set_d;
      glob_clr_q <= glob_clr_d;
      summary_q <= summary_d;
    end
  end

  assign fl.glob_set = glob_set_q;
  assign fl.glob_clr = glob_clr_q;
  assign fl.sector = sector_q;
  assign so = so_q;
  assign so_oe = so_oe_q;
  assign protection_lock_bit = lock_q;
  assign protection_summary_field = summary_q;

  // ========================================================================
  // Checks
  a_hw_lock_freeze: assert property (@(posedge clk) disable iff (rst)
    wsr_done && hw_locked |=> lock_q && !glob_set_q && !glob_clr_q)
    else $error("status write changed state under hard lock");

  a_soft_no_global: assert property (@(posedge clk) disable iff (rst)
    wsr_done && lock_q && wp_n_s |=> !glob_set_q && !glob_clr_q
      && lock_q == $past(byte_in[`LOCK_BIT]))
    else $error("soft lock allowed a global action");

  a_unprotect_all: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in[5:2] == 4'h0 |=> glob_clr_q ##2 !fl.any_prot)
    else $error("global unprotect did not clear the flags");

  a_protect_all: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in[5:2] == 4'hF |=> glob_set_q ##2 fl.all_prot)
    else $error("global protect did not set the flags");

  a_mixed_no_change: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in[5:2] != 4'h0 && byte_in[5:2] != 4'hF
      |=> !glob_set_q && !glob_clr_q)
    else $error("mixed pattern caused a global action");

  a_lock_held_low: assert property (@(posedge clk) disable iff (rst)
    lock_q && !wp_n_s |=> lock_q)
    else $error("lock bit fell while pin held low");

  a_cs_ends_output: assert property (@(posedge clk) disable iff (rst)
    cs_n_s |=> !so_oe_q ##1 (!so_oe_q || !cs_n_s))
    else $error("output still driven after chip select rose");

  a_query_answer: assert property (@(posedge clk) disable iff (rst)
    !cs_n_s && fall && in_query |=> so_oe_q && so_q == $past(fl.flag))
    else $error("query output does not match the sector flag");

  a_status_pin_bit: assert property (@(posedge clk) disable iff (rst)
    !cs_n_s && fall && in_status && ocnt_q == 3'h3
      |=> so_q == $past(wp_n_s))
    else $error("status bit 4 does not follow the pin");

  a_hw_lock_no_glob: assert property (@(posedge clk) disable iff (rst)
    hw_locked |=> !glob_set_q && !glob_clr_q)
    else $error("global action under hard lock");

  a_lock_from_bit7: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !hw_locked |=> lock_q == $past(byte_in[`LOCK_BIT]))
    else $error("lock bit not taken from bit 7 of the write");

  a_write_00_unprotect: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in == 8'h00 |=> glob_clr_q && !lock_q)
    else $error("writing 00h did not unprotect with lock clear");

  a_write_7f_protect: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in == 8'h7F |=> glob_set_q && !lock_q)
    else $error("writing 7Fh did not protect with lock clear");

  a_write_ff_lock: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in == 8'hFF |=> glob_set_q && lock_q)
    else $error("writing FFh did not protect and lock together");

  a_write_0f_unlock: assert property (@(posedge clk) disable iff (rst)
    wsr_done && lock_q && wp_n_s && byte_in == 8'h0F
      |=> !lock_q && !glob_set_q && !glob_clr_q)
    else $error("writing 0Fh did not clear the lock alone");

  a_write_f0_lock: assert property (@(posedge clk) disable iff (rst)
    wsr_done && !lock_q && byte_in == 8'hF0
      |=> lock_q && !glob_set_q && !glob_clr_q)
    else $error("writing F0h did not set the lock alone");

  a_status_bit5_zero: assert property (@(posedge clk) disable iff (rst)
    !cs_n_s && fall && in_status && ocnt_q == 3'h2
      |=> so_q == 1'h0)
    else $error("status bit 5 shows written data");

  a_opcode_query: assert property (@(posedge clk) disable iff (rst)
    byte_done && state_q == sector_protection_lock_pkg::OPCODE_IN
      && byte_in == `OP_READ_PROTECT |=> state_q == sector_protection_lock_pkg::ADDR_IN)
    else $error("query opcode not followed by address phase");

  a_sector_pick: assert property (@(posedge clk) disable iff (rst)
    byte_done && state_q == sector_protection_lock_pkg::ADDR_IN
      && abyte_q == `ADDR_BYTE_SECTOR |=> sector_q == $past(byte_in[3:0]))
    else $error("sector not taken from the first address byte");

  a_query_entry: assert property (@(posedge clk) disable iff (rst)
    byte_done && state_q == sector_protection_lock_pkg::ADDR_IN
      && abyte_q == `ADDR_BYTE_LAST |=> in_query)
    else $error("query output not entered after the third address byte");

  a_summary_all: assert property (@(posedge clk) disable iff (rst)
    fl.all_prot |=> summary_q == `SUMMARY_ALL)
    else $error("summary does not show all sectors protected");

  a_summary_none: assert property (@(posedge clk) disable iff (rst)
    !fl.any_prot |=> summary_q == `SUMMARY_NONE)
    else $error("summary does not show no sectors protected");
endmodule

// *** design/sector_protection_lock_params.svh ***
// Constants for the sector protection lock block
`ifndef SECTOR_PROTECTION_LOCK_PARAMS_SVH
`define SECTOR_PROTECTION_LOCK_PARAMS_SVH

// ==========================================================================
// Serial opcodes
`define OP_WRITE_STATUS 8'h01
`define OP_READ_STATUS 8'h05
`define OP_READ_PROTECT 8'h3C

// ==========================================================================
// Status byte layout
`define LOCK_BIT 7
`define GLOBAL_HI 5
`define GLOBAL_LO 2
`define PIN_BIT 4
`define SUMMARY_HI 3
`define SUMMARY_LO 2
`define GLOBAL_NONE 4'h0
`define GLOBAL_ALL 4'hF

// ==========================================================================
// Summary codes
`define SUMMARY_NONE 2'h0
`define SUMMARY_SOME 2'h1
`define SUMMARY_ALL 2'h3

// ==========================================================================
// Query answers and sectors
`define QUERY_PROTECTED 8'hFF
`define QUERY_UNPROTECTED 8'h00
`define SECTOR_COUNT 16
`define ADDR_BYTE_SECTOR 2'h0
`define ADDR_BYTE_LAST 2'h2
`define BIT_LAST 3'h7

// ==========================================================================
// Reset values
`define LOCK_RESET 1'h0
`define FLAGS_RESET 16'hFFFF

`endif

// *** design/sector_protection_lock_pkg.sv ***
// Types shared by the sector protection lock design
package sector_protection_lock_pkg;
  typedef enum logic [2:0] {
    OPCODE_IN, WSR_DATA, STATUS_OUT, ADDR_IN, QUERY_OUT, IGNORE
  } state_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] sector_t;
endpackage

// *** verification/spi_host.sv ***
// Host serial controller model driving the protection block's pins
`timescale 1ns/1ps
module spi_host #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic so_line,
  output logic cs_n,
  output logic sck,
  output logic si
);
  // ==========================================================
  // Idle: deselected, clock parked low between frames
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================================
  // One frame: ntx bits out, then nrx bits captured on rising sck
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
    output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    wait_clk(HALF);
    for (int i = 0; i < ntx + nrx; i++)
    begin
      si <= (i < ntx) ? tx[ntx - 1 - i] : ~si;
      wait_clk(HALF);
      sck <= 1'b1;
      if (i >= ntx)
        rx = {rx[14:0], so_line};
      wait_clk(HALF);
      sck <= 1'b0;
    end
    wait_clk(HALF);
    cs_n <= 1'b1;
    wait_clk(2 * HALF);
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the sector protection lock block
`timescale 1ns/1ps
`include "sector_protection_lock_params.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  logic protection_lock_bit;
  logic [1:0] protection_summary_field;
  logic [31:0] seed = 32'h0000_0022;
  logic [31:0] rv;
  logic [15:0] rxm;
  int bad_count = 0;
  int check_count = 0;
  int lock_m = 0;
  int flags_m [16];
  logic [8:0] plan [16] = '{9'h100, 9'h17F, 9'h1FF, 9'h100, 9'h1F0, 9'h00F, 9'h000,
    9'h10F, 9'h104, 9'h1B8, 9'h1BC, 9'h13C, 9'h080, 9'h07F, 9'h100, 9'h17F};

  always #2 clk = ~clk;

  // Pull-up on the released output line
  assign so_line = so_oe ? so : 1'b1;

  sector_protection_lock u_sector_protection_lock (
    .clk(clk),
    .rst(rst),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .wp_n(wp_n),
    .so(so),
    .so_oe(so_oe),
    .protection_lock_bit(protection_lock_bit),
    .protection_summary_field(protection_summary_field)
  );

  spi_host u_spi_host (
    .clk(clk),
    .so_line(so_line),
    .cs_n(cs_n),
    .sck(sck),
    .si(si)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Status write under a pin level, then status read and one query
  task automatic step(input logic [8:0] c);
    logic [15:0] rx;
    logic [31:0] r;
    logic [7:0] sb;
    int n;
    @(posedge clk);
    wp_n <= c[8];
    repeat (4) @(posedge clk);
    u_spi_host.frame({16'h0000, `OP_WRITE_STATUS, c[7:0]}, 16, 0, rx);
    if (!(lock_m == 1 && c[8] == 1'b0))
    begin
      if (lock_m == 0 && c[5:2] == 4'h0)
        flags_m = '{default: 0};
      if (lock_m == 0 && c[5:2] == 4'hF)
        flags_m = '{default: 1};
      lock_m = c[7];
    end
    n = 0;
    foreach (flags_m[k])
      n += flags_m[k];
    sb = {lock_m[0], 2'b00, c[8], (n == 0) ? 2'b00 : (n == 16) ? 2'b11 : 2'b01, 2'b00};
    check(16'(protection_lock_bit), 16'(lock_m));
    check(16'(protection_summary_field), 16'(sb[3:2]));
    u_spi_host.frame({24'h00_0000, `OP_READ_STATUS}, 8, 16, rx);
    check(rx, {sb, sb});
    r = rnd();
    u_spi_host.frame({`OP_READ_PROTECT, 4'h0, r[3:0], r[31:16]}, 32, 16, rx);
    check(rx, (flags_m[r[3:0]] == 1) ? 16'hFFFF : 16'h0000);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    flags_m = '{default: 1};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(16'(protection_lock_bit), 16'h0000);
    check(16'(protection_summary_field), 16'h0003);
    // Clear lock, then a separate write for the global action
    foreach (plan[i])
      step(plan[i]);
    // Partial data byte is discarded
    u_spi_host.frame(32'h0000_0020, 13, 0, rxm);
    check(16'(protection_lock_bit), 16'(lock_m));
    check(16'(protection_summary_field), 16'h0003);
    // Query cut short mid-byte
    u_spi_host.frame({`OP_READ_PROTECT, 24'h00_0000}, 32, 5, rxm);
    check(16'(so_oe), 16'h0000);
    check(rxm, (flags_m[0] == 1) ? 16'h001F : 16'h0000);
    repeat (10)
    begin
      rv = rnd();
      step(rv[8:0]);
    end
    summarize();
  end

  // ==========================================================
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
